//--- src/eirm_pkg.sv
// Constants of the interrupt and fast-recovery manager.
// Assumes a 50 MHz master clock and a 32-bit serial frame.
package eirm_pkg;
  localparam int unsigned CLK_HZ   = 50_000_000;
  localparam int unsigned SAT_MS   = 125;
  localparam int unsigned HOLD_MS  = 500;
  localparam int unsigned SAT_CYC  = CLK_HZ / 1000 * SAT_MS;
  localparam int unsigned HOLD_CYC = CLK_HZ / 1000 * HOLD_MS;
  localparam int unsigned TW       = 25;
  // Frame layout: address, read flag, data
  localparam int unsigned FRM_BITS = 32;
  localparam logic [4:0]  LAST_BIT = 5'h1F;
  localparam logic [4:0]  RW_BIT   = 5'h07;
  localparam logic [6:0]  A_STATUS = 7'h01;
  localparam logic [6:0]  A_INT    = 7'h04;
  localparam logic [6:0]  A_DYN    = 7'h05;
  localparam logic [6:0]  A_SWRST  = 7'h08;
  localparam logic [6:0]  A_BEAT_INTERVAL_REGISTER   = 7'h25;
  // interrupt_manager fields
  localparam int unsigned FIFO_IRQ_THRESHOLD_LSB = 19;
  localparam int unsigned CLRF_BIT = 6;
  localparam int unsigned CLRR_LSB = 4;
  localparam int unsigned CLRS_BIT = 2;
  localparam int unsigned RATE_LSB = 0;
  localparam logic [23:0] INT_MASK = 24'hF80077;
  localparam logic [23:0] INT_RST  = 24'h780004;
  // dynamic_mode_manager fields
  localparam int unsigned MODE_LSB = 22;
  localparam int unsigned TH_LSB   = 16;
  localparam logic [23:0] DYN_MASK = 24'hFF0000;
  localparam logic [23:0] DYN_RST  = 24'h3F0000;
  // Status word bit positions
  localparam int unsigned ST_FIFO_THRESHOLD_IRQ  = 23;
  localparam int unsigned ST_FST   = 21;
  localparam int unsigned ST_RR    = 10;
  localparam int unsigned ST_SAMPLE_SYNC_PULSE  = 9;
  typedef enum logic [1:0] {FM_NORMAL = 2'b00, FM_MANUAL = 2'b01,
                            FM_AUTO = 2'b10, FM_RSVD = 2'b11} eirm_fast_t;
  typedef enum logic [1:0] {RC_STATUS = 2'b00, RC_BEAT_INTERVAL_REGISTER = 2'b01,
                            RC_SELF = 2'b10, RC_RSVD = 2'b11} eirm_rrclr_t;
  typedef enum logic [1:0] {AR_IDLE = 2'b00, AR_OVER = 2'b01,
                            AR_HOLD = 2'b10} eirm_auto_t;
endpackage

//--- src/eirm_top.sv
// Interrupt clear, fast-recovery and software reset manager.
// Assumes a serial port master on sclk/csb_n and FIFO/ECG logic on clk.
// Overview of operation
// RULE1: Threshold irq when unread records reach field plus one; field resets 01111.
// RULE2: Clear mode 0: irq held while fast on, then until status read.
// RULE3: Clear mode 1: status read clears; re-armed only by a new fast entry.
// RULE4: Beat irq clears on status read, interval read, or after one period.
// RULE5: Sample pulse self-clears after quarter period, else on status read.
// RULE6: Sample pulse on every 1st, 2nd, 4th or 16th instant; reset 00.
// RULE7: Dynamic writes never touch FIFO state or need a resync.
// RULE8: Fast mode 00 normal, 01 manual until disabled, 11 reserved.
// RULE9: Mode 10 engages fast recovery automatically on saturation.
// RULE10: Over 2048 times threshold for 125 ms engages fast for 500 ms.
// RULE11: Threshold resets to 0x3F; limits are plus and minus.
// RULE12: Software reset restores all defaults at the frame end.
// RULE13: Software reset acts only when the 24 data bits are zero.
// RULE14: Software reset has the same effect as a power cycle.
// RULE15: Sample pulse raised on the base-rate sample instant.
// RULE16: Each term reaches the irq output only when enabled; enables 0.
// RULE17: Threshold irq is evaluated on each FIFO write or read.
`timescale 1ns/1ns
module eirm_top
  import eirm_pkg::*;
#(
  parameter int unsigned SAT_CNT  = SAT_CYC,
  parameter int unsigned HOLD_CNT = HOLD_CYC
)(
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        sclk,
  input  wire logic        csb_n,
  input  wire logic        sdi,
  output logic             sdo,
  input  wire logic        fifo_wr,
  input  wire logic        fifo_rd,
  input  wire logic [5:0]  fifo_count,
  input  wire logic        sample_tick,
  input  wire logic        beat_tick,
  input  wire logic [17:0] ecg_word,
  input  wire logic [3:0]  irq_en,
  output logic             irq_n,
  output logic             fast_active,
  output logic             fifo_threshold_irq,
  output logic             fast_recovery_irq,
  output logic             beat_detect_irq,
  output logic             sample_sync_pulse
);
  localparam logic [TW-1:0] SAT_L  = TW'(SAT_CNT - 1);
  localparam logic [TW-1:0] HOLD_L = TW'(HOLD_CNT - 1);

  // ---- Serial link domain ----
  logic [4:0]  bcnt_q;
  logic [30:0] sh_q;
  logic [23:0] tx_q;
  logic        sdo_q;
  logic [31:0] frame_q;
  logic        tgl_q;
  logic [71:0] snap_q;
  logic [23:0] tx_sel;
  logic [6:0]  rx_addr;

  // Read word picked from the frozen snapshot by the received address
  assign rx_addr = sh_q[6:0];
  assign tx_sel  = (rx_addr == A_STATUS) ? snap_q[71:48] :
                   (rx_addr == A_INT)    ? snap_q[47:24] :
                   (rx_addr == A_DYN)    ? snap_q[23:0]  : 24'h000000;

  // Bit shifter, cleared whenever the chip select is high
  always_ff @(posedge sclk or posedge csb_n)
  begin
    if (csb_n)
    begin
      bcnt_q <= 5'h00;
      sh_q   <= 31'h00000000;
      tx_q   <= 24'h000000;
      sdo_q  <= 1'b0;
    end
    else
    begin
      bcnt_q <= bcnt_q + 5'h01;
      sh_q   <= {sh_q[29:0], sdi};
      if (bcnt_q == RW_BIT)
      begin
        sdo_q <= tx_sel[23];
        tx_q  <= {tx_sel[22:0], 1'b0};
      end
      else
      begin
        sdo_q <= tx_q[23];
        tx_q  <= {tx_q[22:0], 1'b0};
      end
    end
  end

  // Frame capture on the 32nd rising edge, with an event toggle
  always_ff @(posedge sclk or negedge resetn)
  begin
    if (!resetn)
    begin
      frame_q <= 32'h00000000;
      tgl_q   <= 1'b0;
    end
    else if (!csb_n && bcnt_q == LAST_BIT)
    begin
      frame_q <= {sh_q, sdi};   // see RULE12
      tgl_q   <= ~tgl_q;
    end
  end
  assign sdo = sdo_q;

  // ---- Master clock domain ----
  logic        t1_q, t2_q, t3_q;
  logic        cs1_q, cs2_q;
  logic        srst_q;
  logic        rst;
  logic [23:0] int_q, dyn_q;
  eirm_auto_t  ar_q, ar_d;
  logic [TW-1:0] tcnt_q, tcnt_d;
  logic        fast_q, fast_p_q;
  logic        fifo_threshold_irq_q, fst_q, rr_q, sample_sync_pulse_q, irqn_q;
  logic [3:0]  div_q;
  logic [19:0] pcnt_q, per_q, rtmr_q, stmr_q;

  // Two-stage synchronisers for the frame toggle and the chip select
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      t1_q  <= 1'b0;
      t2_q  <= 1'b0;
      t3_q  <= 1'b0;
      cs1_q <= 1'b1;
      cs2_q <= 1'b1;
    end
    else
    begin
      t1_q  <= tgl_q;
      t2_q  <= t1_q;
      t3_q  <= t2_q;
      cs1_q <= csb_n;
      cs2_q <= cs1_q;
    end
  end

  // Frame decode
  logic        frm_ev, wr_ev, rd_ev, st_rd, beat_interval_register_rd, srst_d;
  logic [6:0]  f_addr;
  logic [23:0] f_data;
  assign frm_ev  = t2_q ^ t3_q;
  assign f_addr  = frame_q[31:25];
  assign f_data  = frame_q[23:0];
  assign wr_ev   = frm_ev & ~frame_q[24];
  assign rd_ev   = frm_ev & frame_q[24];
  assign st_rd   = rd_ev & (f_addr == A_STATUS);
  assign beat_interval_register_rd = rd_ev & (f_addr == A_BEAT_INTERVAL_REGISTER);
  assign srst_d  = wr_ev & (f_addr == A_SWRST) & (f_data == 24'h000000); // see RULE13
  assign rst     = ~resetn | srst_q;                                     // see RULE14

  // Software reset strobe, high for the one cycle after an accepted reset frame
  always_ff @(posedge clk)
  begin
    if (!resetn)
      srst_q <= 1'b0;
    else
      srst_q <= srst_d;
  end

  // Register fields
  logic [4:0]  fifo_irq_threshold;
  logic        fast_irq_clear_mode, sample_pulse_clear_mode;
  eirm_rrclr_t rr_mode;
  logic [1:0]  rate;
  eirm_fast_t  fmode;
  logic [5:0]  fth;
  assign fifo_irq_threshold     = int_q[FIFO_IRQ_THRESHOLD_LSB +: 5];
  assign fast_irq_clear_mode = int_q[CLRF_BIT];
  assign rr_mode  = eirm_rrclr_t'(int_q[CLRR_LSB +: 2]);
  assign sample_pulse_clear_mode = int_q[CLRS_BIT];
  assign rate     = int_q[RATE_LSB +: 2];
  assign fmode    = eirm_fast_t'(dyn_q[MODE_LSB +: 2]);
  assign fth      = dyn_q[TH_LSB +: 6];

  // Register writes; dynamic writes leave FIFO state alone
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      int_q <= INT_RST;   // see RULE1
      dyn_q <= DYN_RST;   // see RULE11
    end
    else if (wr_ev && f_addr == A_INT)
      int_q <= f_data & INT_MASK;
    else if (wr_ev && f_addr == A_DYN)
      dyn_q <= f_data & DYN_MASK;   // see RULE7
  end

  // Saturation test against symmetric limits
  logic signed [17:0] thr_pos, thr_neg, ecg_s;
  logic               over, is_auto;
  assign thr_pos = {1'b0, fth, 11'h000};   // see RULE10
  assign thr_neg = -thr_pos;               // see RULE11
  assign ecg_s   = ecg_word;
  assign over    = (ecg_s > thr_pos) | (ecg_s < thr_neg);
  assign is_auto = (fmode == FM_AUTO);     // see RULE9

  // Automatic recovery sequencer: qualify then hold
  always_comb
  begin
    ar_d   = ar_q;
    tcnt_d = tcnt_q + TW'(1);
    case (ar_q)
      AR_IDLE:
      begin
        tcnt_d = '0;
        if (is_auto && over)
          ar_d = AR_OVER;
      end
      AR_OVER:
      begin
        if (!is_auto || !over)
          ar_d = AR_IDLE;
        else if (tcnt_q == SAT_L)
        begin
          ar_d   = AR_HOLD;   // see RULE10
          tcnt_d = '0;
        end
      end
      AR_HOLD:
      begin
        if (!is_auto || tcnt_q == HOLD_L)
          ar_d = AR_IDLE;     // see RULE10
      end
      default:
        ar_d = AR_IDLE;
    endcase
  end

  // Fast recovery engagement
  logic fast_d, fst_set, fst_d;
  assign fast_d  = (fmode == FM_MANUAL) | (ar_q == AR_HOLD); // see RULE8
  assign fst_set = fast_irq_clear_mode ? (fast_q & ~fast_p_q) : fast_q; // see RULE2 see RULE3
  assign fst_d   = fst_set | (fst_q & ~st_rd);

  // Sample pulse rate and clearing
  logic [3:0] rmask;
  logic       s_issue, s_clr, sample_sync_pulse_d;
  logic [19:0] qtr;
  assign rmask   = (rate == 2'b00) ? 4'h0 : (rate == 2'b01) ? 4'h1 :
                   (rate == 2'b10) ? 4'h3 : 4'hF;
  assign s_issue = sample_tick & ((div_q & rmask) == 4'h0); // see RULE6 see RULE15
  assign qtr     = (per_q[19:2] == 18'h0) ? 20'h00001 : {2'b00, per_q[19:2]};
  assign s_clr   = sample_pulse_clear_mode ? (stmr_q >= qtr) : st_rd;      // see RULE5
  assign sample_sync_pulse_d  = s_issue | (sample_sync_pulse_q & ~s_clr);

  // Beat interrupt clearing
  logic r_clr, rr_d;
  assign r_clr = (rr_mode == RC_BEAT_INTERVAL_REGISTER) ? beat_interval_register_rd :
                 (rr_mode == RC_SELF) ? (rtmr_q >= per_q) : st_rd; // see RULE4
  assign rr_d  = beat_tick | (rr_q & ~r_clr);

  // Threshold compare and unmasked interrupt term vector
  logic       fifo_threshold_irq_d;
  logic [3:0] terms;
  assign fifo_threshold_irq_d = {1'b0, fifo_count} >= ({2'b00, fifo_irq_threshold} + 7'h01); // see RULE1
  assign terms  = {fifo_threshold_irq_q, fst_q, rr_q, sample_sync_pulse_q};

  // Sequencer and fast state
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      ar_q     <= AR_IDLE;
      tcnt_q   <= '0;
      fast_q   <= 1'b0;
      fast_p_q <= 1'b0;
    end
    else
    begin
      ar_q     <= ar_d;
      tcnt_q   <= tcnt_d;
      fast_q   <= fast_d;
      fast_p_q <= fast_q;
    end
  end

  // Interrupt flags; a set in the clear cycle wins
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      fifo_threshold_irq_q <= 1'b0;
      fst_q  <= 1'b0;
      rr_q   <= 1'b0;
      sample_sync_pulse_q <= 1'b0;
      irqn_q <= 1'b1;
    end
    else
    begin
      if (fifo_wr || fifo_rd)
        fifo_threshold_irq_q <= fifo_threshold_irq_d;                 // see RULE17
      fst_q  <= fst_d;
      rr_q   <= rr_d;
      sample_sync_pulse_q <= sample_sync_pulse_d;
      irqn_q <= ~(|(terms & irq_en));     // see RULE16
    end
  end

  // Sample divider, period measure and self-clear timers
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      div_q  <= 4'h0;
      pcnt_q <= 20'h00000;
      per_q  <= 20'hFFFFF;
      rtmr_q <= 20'h00000;
      stmr_q <= 20'h00000;
    end
    else
    begin
      if (sample_tick)
      begin
        div_q  <= div_q + 4'h1;
        per_q  <= pcnt_q + 20'h00001;
        pcnt_q <= 20'h00000;
      end
      else if (pcnt_q != 20'hFFFFF)
        pcnt_q <= pcnt_q + 20'h00001;
      rtmr_q <= beat_tick ? 20'h00001 : (rr_q ? rtmr_q + 20'h00001 : 20'h00000);
      stmr_q <= s_issue ? 20'h00001 : (sample_sync_pulse_q ? stmr_q + 20'h00001 : 20'h00000);
    end
  end

  // Read snapshot, frozen while a frame is in progress
  logic [23:0] st_word;
  always_comb
  begin
    st_word          = 24'h000000;
    st_word[ST_FIFO_THRESHOLD_IRQ] = fifo_threshold_irq_q;
    st_word[ST_FST]  = fst_q;
    st_word[ST_RR]   = rr_q;
    st_word[ST_SAMPLE_SYNC_PULSE] = sample_sync_pulse_q;
  end
  always_ff @(posedge clk)
  begin
    if (rst)
      snap_q <= {24'h000000, INT_RST, DYN_RST};
    else if (cs2_q)
      snap_q <= {st_word, int_q, dyn_q};
  end

  assign irq_n              = irqn_q;
  assign fast_active        = fast_q;
  assign fifo_threshold_irq = fifo_threshold_irq_q;
  assign fast_recovery_irq  = fst_q;
  assign beat_detect_irq    = rr_q;
  assign sample_sync_pulse  = sample_sync_pulse_q;

  // ---- Checks ----
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn || srst_q);

  sequence fast_stays_s;
    fast_q && fast_p_q;
  endsequence

  fifo_irq_threshold_eval_a: assert property ((fifo_wr || fifo_rd) |=> fifo_threshold_irq_q == $past(fifo_threshold_irq_d)) // see RULE1
    else $error("threshold irq not evaluated on FIFO access");
  fst_hold_a: assert property (fast_q && !fast_irq_clear_mode |=> fst_q) // see RULE2
    else $error("fast irq dropped while fast mode engaged");
  fst_once_a: assert property (fast_stays_s ##0 (fast_irq_clear_mode && !fst_q) |=> !fst_q) // see RULE3
    else $error("fast irq re-asserted without new entry");
  beat_clr_a: assert property (rr_q && rr_mode == RC_STATUS && st_rd && !beat_tick
                               |=> !rr_q) // see RULE4
    else $error("beat irq not cleared by status read");
  sample_sync_pulse_keep_a: assert property (!sample_pulse_clear_mode && sample_sync_pulse_q && !st_rd |=> sample_sync_pulse_q) // see RULE5
    else $error("sample pulse cleared without status read");
  sample_sync_pulse_rate_a: assert property (!sample_sync_pulse_q && sample_tick && rate == 2'b11 && div_q != 4'h0
                                |=> !sample_sync_pulse_q) // see RULE6
    else $error("sample pulse issued off the rate");
  auto_eng_a: assert property (ar_q == AR_OVER && tcnt_q == SAT_L && over && is_auto
                               |=> ##1 fast_q) // see RULE10
    else $error("auto fast recovery not engaged");
  manual_a: assert property (fmode == FM_MANUAL |=> fast_q) // see RULE8
    else $error("manual fast recovery not active");
  normal_a: assert property (fmode == FM_NORMAL [*2] |=> !fast_q) // see RULE8
    else $error("fast active in normal mode");
  swrst_bad_a: assert property (wr_ev && f_addr == A_SWRST && f_data != 24'h000000
                                |=> !srst_q) // see RULE13
    else $error("software reset taken with nonzero data");
  mask_a: assert property (irq_en == 4'h0 |=> irqn_q) // see RULE16
    else $error("masked term reached irq output");
endmodule

//--- verif/eirm_host.sv
// Host model that masters the serial port of the manager.
// Assumes sdo is updated after sclk rises; sclk stands still between frames.
`timescale 1ns/1ns
module eirm_host (
  output logic      sclk,
  output logic      csb_n,
  output logic      sdi,
  input  wire logic sdo
);
  // Idle line state
  initial
  begin
    sclk = 1'h0;
    csb_n = 1'h1;
    sdi = 1'h0;
  end
  // One whole 32-bit frame, MSB first; read bits taken just before each rise
  task automatic xfer(input logic [6:0] a, input logic rd, input logic [23:0] d,
                      output logic [23:0] q);
    logic [31:0] f;
    f = {a, rd, d};
    q = 24'h0;
    csb_n = 1'h0;
    #102;
    for (int i = 31; i >= 0; i--)
    begin
      sdi = f[i];
      #3;
      if (i < 24) q[i] = sdo;
      sclk = 1'h1;
      #3;
      sclk = 1'h0;
    end
    // Released data line must not keep its last value
    sdi = ~sdi;
    #3;
    csb_n = 1'h1;
    #120;
  endtask
endmodule

//--- verif/eirm_top_tb.sv
// Self-checking bench of the interrupt and fast-recovery manager.
// Assumes the host model above and short saturation and hold counts.
`timescale 1ns/1ns
module eirm_top_tb;
  import eirm_pkg::*;
  logic        clk, resetn, sclk, csb_n, sdi, sdo, fifo_wr, fifo_rd;
  logic        sample_tick, beat_tick, irq_n, fast_active;
  logic        f_thr, f_fast, f_beat, f_sample_sync_pulse;
  logic [5:0]  fifo_count;
  logic [17:0] ecg_word;
  logic [3:0]  irq_en;
  logic [23:0] q, mdl_int, mdl_dyn;
  int          num_errors, samples_checked, seed, n, t, m_int;
  eirm_top #(.SAT_CNT(20), .HOLD_CNT(50)) eirm_top_i (
    .clk(clk), .resetn(resetn), .sclk(sclk), .csb_n(csb_n), .sdi(sdi), .sdo(sdo),
    .fifo_wr(fifo_wr), .fifo_rd(fifo_rd), .fifo_count(fifo_count),
    .sample_tick(sample_tick), .beat_tick(beat_tick), .ecg_word(ecg_word),
    .irq_en(irq_en), .irq_n(irq_n), .fast_active(fast_active),
    .fifo_threshold_irq(f_thr), .fast_recovery_irq(f_fast),
    .beat_detect_irq(f_beat), .sample_sync_pulse(f_sample_sync_pulse));
  eirm_host host_i (.sclk(sclk), .csb_n(csb_n), .sdi(sdi), .sdo(sdo));
  // Master clock
  initial
  begin
    clk = 1'h0;
    forever #10 clk = ~clk;
  end
  // Base-rate sample instants every 40 cycles; pulse edges counted
  initial
  begin
    sample_tick = 1'h0;
    forever
    begin
      repeat (39) @(negedge clk);
      sample_tick = 1'h1;
      @(negedge clk);
      sample_tick = 1'h0;
    end
  end
  always @(posedge f_sample_sync_pulse) n = n + 1;
  task automatic chk(input logic [23:0] seen, input logic [23:0] exp, input string what);
    samples_checked++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("MISMATCH %s exp %h seen %h", what, exp, seen);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(negedge clk);
  endtask
  // Register model kept from the field masks and reset values
  task automatic wr(input logic [6:0] a, input logic [23:0] d);
    host_i.xfer(a, 1'h0, d, q);
    cyc(4);
    if (a == A_INT)
      mdl_int = d & INT_MASK;
    else if (a == A_DYN)
      mdl_dyn = d & DYN_MASK;
    else if (a == A_SWRST && d == 24'h000000)
    begin
      mdl_int = INT_RST;
      mdl_dyn = DYN_RST;
    end
  endtask
  // Every non-status read is compared with the model
  task automatic rd(input logic [6:0] a);
    logic [23:0] e;
    e = (a == A_INT) ? mdl_int : (a == A_DYN) ? mdl_dyn : 24'h000000;
    host_i.xfer(a, 1'h1, 24'h0, q);
    cyc(4);
    if (a != A_STATUS)
      chk(q, e, "reg_model");
  endtask
  task automatic conclude;
    $display("TB: errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // Watchdog
  initial
  begin
    #1_000_000;
    num_errors++;
    conclude();
  end
  // Main sequence
  initial
  begin
    seed = 26025;
    {resetn, fifo_wr, fifo_rd, beat_tick} = 4'h0;
    mdl_int = INT_RST;
    mdl_dyn = DYN_RST;
    fifo_count = 6'h00;
    ecg_word = 18'h00000;
    irq_en = 4'h0;
    repeat (20) @(negedge clk);
    resetn = 1'h1;
    cyc(3);
    rd(A_INT);
    chk(q, 24'h780004, "int_reset");
    rd(A_DYN);
    chk(q, 24'h3F0000, "dyn_reset");
    rd(7'h03);
    chk(q, 24'h0, "unmapped");
    m_int = $random(seed);
    wr(A_INT, 24'(m_int));
    rd(A_INT);
    chk(q, 24'(m_int) & INT_MASK, "int_rw");
    $display("TB: registers done");
    // Threshold boundaries with write and read pulses
    for (int k = 0; k < 4; k++)
    begin
      t = (k == 0) ? 0 : (k == 1) ? 31 : $unsigned($random(seed)) % 32;
      wr(A_INT, 24'(t << FIFO_IRQ_THRESHOLD_LSB) | 24'h000004);
      for (int c = t; c <= t + 1; c++)
      begin
        fifo_count = 6'(c);
        fifo_wr = (c == t);
        fifo_rd = (c != t);
        cyc(1);
        {fifo_wr, fifo_rd} = 2'h0;
        cyc(1);
        chk(f_thr, c >= t + 1, "fifo_thr");
      end
    end
    wr(A_DYN, 24'h050000);
    chk(f_thr, 1'h1, "fifo_kept");
    chk(irq_n, 1'h1, "irq_masked");
    irq_en = 4'h8;
    cyc(2);
    chk(irq_n, 1'h0, "irq_enabled");
    irq_en = 4'h0;
    $display("TB: fifo done");
    // Sample pulse rates and self-clear width
    for (int r = 0; r < 4; r++)
    begin
      wr(A_INT, 24'(4 + r));
      @(posedge f_sample_sync_pulse);
      cyc(5);
      chk(f_sample_sync_pulse, 1'h1, "sample_sync_pulse_high");
      cyc(8);
      chk(f_sample_sync_pulse, 1'h0, "sample_sync_pulse_self");
      t = n;
      cyc(1280);
      chk(24'(n - t), 24'(r == 3 ? 2 : 32 >> r), "sample_sync_pulse_rate");
    end
    wr(A_INT, 24'h0);
    @(posedge sample_tick);
    cyc(2);
    chk(f_sample_sync_pulse, 1'h1, "sample_sync_pulse_sticky");
    rd(A_STATUS);
    chk(f_sample_sync_pulse, 1'h0, "sample_sync_pulse_read");
    $display("TB: sample done");
    // Beat clear modes
    for (int m = 0; m < 3; m++)
    begin
      wr(A_INT, 24'(4 | m << CLRR_LSB));
      @(posedge sample_tick);
      cyc(2);
      beat_tick = 1'h1;
      cyc(1);
      beat_tick = 1'h0;
      rd(A_STATUS);
      chk(f_beat, m != 0, "beat_status");
      rd(A_BEAT_INTERVAL_REGISTER);
      chk(f_beat, 1'h0, "beat_later");
    end
    // Manual fast recovery under both clear behaviours
    for (int cf = 0; cf < 2; cf++)
    begin
      wr(A_INT, 24'(4 | cf << CLRF_BIT));
      wr(A_DYN, 24'h7F0000);
      chk({fast_active, f_fast}, 2'h3, "fast_on");
      rd(A_STATUS);
      chk(f_fast, cf == 0, "fast_read");
      wr(A_DYN, 24'h3F0000);
      chk({fast_active, f_fast}, 2'(cf == 0), "fast_off");
      rd(A_STATUS);
      chk(f_fast, 1'h0, "fast_clear");
    end
    // Automatic recovery at the saturation limit
    wr(A_DYN, 24'h810000);
    ecg_word = 18'h3F800;
    cyc(40);
    chk(fast_active, 1'h0, "auto_limit");
    ecg_word = ($random(seed) & 1) ? 18'h3F7FF : 18'h00801;
    cyc(15);
    chk(fast_active, 1'h0, "auto_early");
    cyc(10);
    ecg_word = 18'h00000;
    chk(fast_active, 1'h1, "auto_on");
    cyc(40);
    chk(fast_active, 1'h1, "auto_hold");
    cyc(15);
    chk(fast_active, 1'h0, "auto_end");
    // Software reset refused then taken
    wr(A_INT, 24'h880044);
    wr(A_SWRST, 24'h000100);
    rd(A_INT);
    chk(q, 24'h880044, "srst_nonzero");
    wr(A_SWRST, 24'h0);
    rd(A_INT);
    chk(q, INT_RST, "srst_int");
    rd(A_DYN);
    chk(q, DYN_RST, "srst_dyn");
    chk(f_thr, 1'h0, "srst_flag");
    $display("TB: modes done");
    conclude();
  end
endmodule
